// *** hdl/flow_treatment_pkg.sv ***
// package: constants and field layout for the flow treatment decoder
package flow_treatment_pkg;
  // treatment word layout
  localparam int TW_WIDTH       = 16;
  localparam int DS_WIDTH       = 8;
  localparam int DS_LSB         = 8;
  localparam int FULL_BIT       = 7;
  localparam int REPL_BIT       = 6;
  localparam int MARK_BIT       = 5;
  localparam int DROP_BIT       = 4;
  localparam int HOST_BIT       = 3;
  localparam int QUEUE_LSB      = 0;
  localparam int QUEUE_WIDTH    = 3;
  localparam int QT_WIDTH       = 5;
  localparam int DS_PART_WIDTH  = 6;
  localparam int NUM_QUEUES     = 8;
  localparam int PORTMAP_WIDTH  = 16;
  localparam int SLOT_WIDTH     = 4;
  localparam int ADDR_WIDTH     = 32;
  localparam int TPORT_WIDTH    = 16;
  localparam int KEY_WIDTH      = 2 * ADDR_WIDTH + 2 * TPORT_WIDTH + SLOT_WIDTH;
  localparam int CAM_KEY_WIDTH  = 64;
  localparam int ROUTE_TRITS    = 32;
  localparam int INDEX_WIDTH    = 16;
  localparam int REASON_WIDTH   = 8;
  localparam logic [SLOT_WIDTH-1:0] HOST_SLOT = 4'h0;
  localparam logic [REASON_WIDTH-1:0] REASON_FLOW_DIVERT = 8'h01;
  localparam logic [REASON_WIDTH-1:0] REASON_NONE        = 8'h00;

  // register map, byte addresses
  localparam logic [11:0] CTRL_OFFSET       = 12'h000;
  localparam logic [11:0] STATUS_OFFSET     = 12'h004;
  localparam logic [11:0] DROP_CNT_OFFSET   = 12'h008;
  localparam logic [11:0] DIVERT_CNT_OFFSET = 12'h00c;
  localparam logic [11:0] LAST_TW_OFFSET    = 12'h010;
  localparam logic [11:0] FWD_CNT_OFFSET    = 12'h014;
  localparam int CTRL_MCAST_BIT  = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/treatment_word_if.sv ***
// interface: decoded fields of one treatment word
`timescale 1ns/1ps
interface treatment_word_if;
  logic [flow_treatment_pkg::TW_WIDTH-1:0]      word;
  logic [flow_treatment_pkg::DS_WIDTH-1:0]      ds_value;
  logic                                          full_width_replace;
  logic                                          replace_req;
  logic                                          access_mark;
  logic                                          drop;
  logic                                          host_divert;
  logic [flow_treatment_pkg::QUEUE_WIDTH-1:0]   queue_num;
  modport decoder (input word, output ds_value, full_width_replace, replace_req, access_mark, drop,
                   host_divert, queue_num);
  modport user    (output word, input ds_value, full_width_replace, replace_req, access_mark, drop,
                   host_divert, queue_num);
endinterface

// *** hdl/treatment_field_split.sv ***
// leaf: splits a treatment word into its fields
`timescale 1ns/1ps
module treatment_field_split #(
  parameter int DS_LSB_P    = flow_treatment_pkg::DS_LSB,
  parameter int FULL_BIT_P  = flow_treatment_pkg::FULL_BIT,
  parameter int REPL_BIT_P  = flow_treatment_pkg::REPL_BIT,
  parameter int MARK_BIT_P  = flow_treatment_pkg::MARK_BIT,
  parameter int DROP_BIT_P  = flow_treatment_pkg::DROP_BIT,
  parameter int HOST_BIT_P  = flow_treatment_pkg::HOST_BIT,
  parameter int QUEUE_LSB_P = flow_treatment_pkg::QUEUE_LSB
) (
  treatment_word_if.decoder tw
);
  assign tw.ds_value           = tw.word[DS_LSB_P +: flow_treatment_pkg::DS_WIDTH];
  assign tw.full_width_replace = tw.word[FULL_BIT_P];
  assign tw.replace_req        = tw.word[REPL_BIT_P];
  assign tw.access_mark        = tw.word[MARK_BIT_P];
  assign tw.drop               = tw.word[DROP_BIT_P];
  assign tw.host_divert        = tw.word[HOST_BIT_P];
  assign tw.queue_num          = tw.word[QUEUE_LSB_P +: flow_treatment_pkg::QUEUE_WIDTH];
endmodule

// *** hdl/flow_treatment_decode.sv ***
// top: per-packet treatment decode with an AXI4-Lite control slave
`timescale 1ns/1ps
module flow_treatment_decode #(
  parameter int DS_LSB_P    = flow_treatment_pkg::DS_LSB,
  parameter int FULL_BIT_P  = flow_treatment_pkg::FULL_BIT,
  parameter int REPL_BIT_P  = flow_treatment_pkg::REPL_BIT,
  parameter int MARK_BIT_P  = flow_treatment_pkg::MARK_BIT,
  parameter int DROP_BIT_P  = flow_treatment_pkg::DROP_BIT,
  parameter int HOST_BIT_P  = flow_treatment_pkg::HOST_BIT,
  parameter int QUEUE_LSB_P = flow_treatment_pkg::QUEUE_LSB
) (
  input  wire logic                                            mclk,
  input  wire logic                                            reset,
  // packet header in
  input  wire logic                                            pkt_valid,
  input  wire logic [flow_treatment_pkg::ADDR_WIDTH-1:0]       src_addr,
  input  wire logic [flow_treatment_pkg::ADDR_WIDTH-1:0]       dst_addr,
  input  wire logic [flow_treatment_pkg::TPORT_WIDTH-1:0]      src_tport,
  input  wire logic [flow_treatment_pkg::TPORT_WIDTH-1:0]      dst_tport,
  input  wire logic [flow_treatment_pkg::SLOT_WIDTH-1:0]       bus_slot_port,
  input  wire logic [flow_treatment_pkg::DS_WIDTH-1:0]         pkt_ds,
  input  wire logic                                            pkt_multicast,
  // lookup results in
  input  wire logic                                            flow_hit,
  input  wire logic [flow_treatment_pkg::TW_WIDTH-1:0]         flow_assoc_data,
  input  wire logic [flow_treatment_pkg::TW_WIDTH-1:0]         src_default_word,
  input  wire logic [flow_treatment_pkg::TW_WIDTH-1:0]         dst_default_word,
  input  wire logic [flow_treatment_pkg::PORTMAP_WIDTH-1:0]    route_portmap,
  input  wire logic [flow_treatment_pkg::SLOT_WIDTH-1:0]       mcast_expected_slot,
  input  wire logic [flow_treatment_pkg::INDEX_WIDTH-1:0]      route_match_index,
  input  wire logic [flow_treatment_pkg::INDEX_WIDTH-1:0]      transport_match_index,
  // lookup keys out
  output logic [flow_treatment_pkg::KEY_WIDTH-1:0]             flow_key,
  output logic [flow_treatment_pkg::CAM_KEY_WIDTH-1:0]         binary_flow_cam_key,
  output logic [flow_treatment_pkg::ROUTE_TRITS-1:0]           ternary_route_cam_key,
  output logic [flow_treatment_pkg::TPORT_WIDTH-1:0]           src_default_index,
  output logic [flow_treatment_pkg::TPORT_WIDTH-1:0]           dst_default_index,
  // write-back of accessed word
  output logic                                                 mark_wr,
  output logic [flow_treatment_pkg::TW_WIDTH-1:0]              mark_wr_word,
  // control bus out
  output logic                                                 out_valid,
  output logic                                                 out_drop,
  output logic [flow_treatment_pkg::PORTMAP_WIDTH-1:0]         out_portmap,
  output logic [flow_treatment_pkg::QUEUE_WIDTH-1:0]           out_queue,
  output logic [flow_treatment_pkg::DS_WIDTH-1:0]              out_ds,
  output logic [flow_treatment_pkg::REASON_WIDTH-1:0]          out_reason,
  output logic [flow_treatment_pkg::INDEX_WIDTH-1:0]           out_route_index,
  output logic [flow_treatment_pkg::INDEX_WIDTH-1:0]           out_transport_index,
  // AXI4-Lite slave
  input  wire logic [11:0]                                     s_axi_awaddr,
  input  wire logic                                            s_axi_awvalid,
  output logic                                                 s_axi_awready,
  input  wire logic [31:0]                                     s_axi_wdata,
  input  wire logic [3:0]                                      s_axi_wstrb,
  input  wire logic                                            s_axi_wvalid,
  output logic                                                 s_axi_wready,
  output logic [1:0]                                           s_axi_bresp,
  output logic                                                 s_axi_bvalid,
  input  wire logic                                            s_axi_bready,
  input  wire logic [11:0]                                     s_axi_araddr,
  input  wire logic                                            s_axi_arvalid,
  output logic                                                 s_axi_arready,
  output logic [31:0]                                          s_axi_rdata,
  output logic [1:0]                                           s_axi_rresp,
  output logic                                                 s_axi_rvalid,
  input  wire logic                                            s_axi_rready
);

  // compare queue numbers; lower number means higher priority
  function automatic logic first_wins(input logic [flow_treatment_pkg::QUEUE_WIDTH-1:0] qa,
                                      input logic [flow_treatment_pkg::QUEUE_WIDTH-1:0] qb);
    first_wins = (qa <= qb);
  endfunction

  // one decode of the register map, shared by the write and read sides
  function automatic logic reg_mapped(input logic [11:0] addr);
    reg_mapped = (addr == flow_treatment_pkg::CTRL_OFFSET) ||
                 (addr == flow_treatment_pkg::STATUS_OFFSET) ||
                 (addr == flow_treatment_pkg::DROP_CNT_OFFSET) ||
                 (addr == flow_treatment_pkg::DIVERT_CNT_OFFSET) ||
                 (addr == flow_treatment_pkg::LAST_TW_OFFSET) ||
                 (addr == flow_treatment_pkg::FWD_CNT_OFFSET);
  endfunction

  // control, statistics and capture registers
  logic [31:0] ctrl_reg;
  logic [31:0] drop_cnt_reg;
  logic [31:0] divert_cnt_reg;
  logic [31:0] fwd_cnt_reg;
  logic [flow_treatment_pkg::TW_WIDTH-1:0] last_tw_reg;
  logic        last_hit_reg;
  logic        last_mcast_fail_reg;

  // control bits decoded once, read by the fate and status logic
  wire mcast_check_en = ctrl_reg[flow_treatment_pkg::CTRL_MCAST_BIT]; // multicast_ingress_check
  wire decode_en      = ctrl_reg[flow_treatment_pkg::CTRL_ENABLE_BIT];

  // treatment word selection
  // both default words are read every cycle, hit or miss, so a miss costs no extra cycle
  wire [flow_treatment_pkg::QUEUE_WIDTH-1:0] src_q =
    src_default_word[QUEUE_LSB_P +: flow_treatment_pkg::QUEUE_WIDTH];
  wire [flow_treatment_pkg::QUEUE_WIDTH-1:0] dst_q =
    dst_default_word[QUEUE_LSB_P +: flow_treatment_pkg::QUEUE_WIDTH];
  wire [flow_treatment_pkg::TW_WIDTH-1:0] default_word =
    first_wins(src_q, dst_q) ? src_default_word : dst_default_word;
  // flow hit has precedence over the concurrent default read
  wire [flow_treatment_pkg::TW_WIDTH-1:0] chosen_word =
    flow_hit ? flow_assoc_data : default_word;

  // field split sits in its own module so the bit positions stay parameters
  treatment_word_if tw ();
  assign tw.word = chosen_word;
  treatment_field_split #(
    .DS_LSB_P    (DS_LSB_P),
    .FULL_BIT_P  (FULL_BIT_P),
    .REPL_BIT_P  (REPL_BIT_P),
    .MARK_BIT_P  (MARK_BIT_P),
    .DROP_BIT_P  (DROP_BIT_P),
    .HOST_BIT_P  (HOST_BIT_P),
    .QUEUE_LSB_P (QUEUE_LSB_P)
  ) u_split (
    .tw (tw.decoder)
  );

  // lookup keys, formed straight from the header
  assign flow_key = {src_addr, dst_addr, src_tport, dst_tport, bus_slot_port};
  // exact-match key holds the two ports and the folded addresses
  // limitation: the fold maps distinct address pairs onto one key
  assign binary_flow_cam_key = {src_addr ^ dst_addr, src_tport, dst_tport};
  assign ternary_route_cam_key = dst_addr;
  assign src_default_index     = src_tport;
  assign dst_default_index     = dst_tport;

  // packet fate
  // drop beats divert: a packet refused at ingress must not reach the host either
  wire mcast_fail = mcast_check_en && pkt_multicast && (bus_slot_port != mcast_expected_slot);
  wire drop_now   = tw.drop || mcast_fail;
  wire divert_now = tw.host_divert && !drop_now;

  // host port is one bit of the map, never merged with the route map
  logic [flow_treatment_pkg::PORTMAP_WIDTH-1:0] host_map;
  assign host_map = flow_treatment_pkg::PORTMAP_WIDTH'(1) << flow_treatment_pkg::HOST_SLOT;
  wire [flow_treatment_pkg::PORTMAP_WIDTH-1:0] portmap_next =
    drop_now ? '0 : (divert_now ? host_map : route_portmap);

  // per-bit DS merge on a replace request: upper six from the word, lower two only for full width
  logic [flow_treatment_pkg::DS_WIDTH-1:0] ds_next;
  genvar gi;
  generate
    for (gi = 0; gi < flow_treatment_pkg::DS_WIDTH; gi++) begin : g_ds
      localparam bit UPPER = gi >= (flow_treatment_pkg::DS_WIDTH - flow_treatment_pkg::DS_PART_WIDTH);
      assign ds_next[gi] = (tw.replace_req && (UPPER || tw.full_width_replace)) ?
                           tw.ds_value[gi] : pkt_ds[gi];
    end
  endgenerate

  // with decode off headers pass unseen: no result, no count, no write-back
  wire take = pkt_valid && decode_en;

  // result pulses stand for one cycle only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      mark_wr   <= 1'b0;
    end else begin
      out_valid <= take;
      mark_wr   <= take && flow_hit;
    end
  end

  // result fields hold until the next taken header
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      out_drop            <= 1'b0;
      out_portmap         <= '0;
      out_queue           <= '0;
      out_ds              <= '0;
      out_reason          <= flow_treatment_pkg::REASON_NONE;
      out_route_index     <= '0;
      out_transport_index <= '0;
      mark_wr_word        <= '0;
    end else if (take) begin
      out_drop            <= drop_now;
      out_portmap         <= portmap_next;
      out_queue           <= tw.queue_num;
      out_ds              <= ds_next;
      out_reason          <= divert_now ? flow_treatment_pkg::REASON_FLOW_DIVERT
                                        : flow_treatment_pkg::REASON_NONE;
      out_route_index     <= route_match_index;
      out_transport_index <= transport_match_index;
      // whole word goes back, so the store needs no read-modify-write
      mark_wr_word        <= flow_assoc_data | (flow_treatment_pkg::TW_WIDTH'(1) << MARK_BIT_P);
    end
  end

  // statistics, counted only for taken headers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      drop_cnt_reg        <= '0;
      divert_cnt_reg      <= '0;
      fwd_cnt_reg         <= '0;
      last_tw_reg         <= '0;
      last_hit_reg        <= 1'b0;
      last_mcast_fail_reg <= 1'b0;
    end else if (take) begin
      drop_cnt_reg        <= drop_cnt_reg + 32'(drop_now);
      divert_cnt_reg      <= divert_cnt_reg + 32'(divert_now);
      fwd_cnt_reg         <= fwd_cnt_reg + 32'(!drop_now && !divert_now);
      last_tw_reg         <= chosen_word;
      last_hit_reg        <= flow_hit;
      last_mcast_fail_reg <= mcast_fail;
    end
  end

  // register bus, write side
  logic        aw_held_reg;
  logic [11:0] aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;

  // one write in flight: both channels stall until the response is taken
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  wire        wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;
  wire        wr_ctrl   = wr_fire && (aw_addr_reg == flow_treatment_pkg::CTRL_OFFSET);
  wire        wr_mapped = reg_mapped(aw_addr_reg);

  // byte strobes honoured on the one writable register
  logic [31:0] ctrl_next;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign ctrl_next[gi*8 +: 8] = w_strb_reg[gi] ? w_data_reg[gi*8 +: 8] : ctrl_reg[gi*8 +: 8];
    end
  endgenerate

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= flow_treatment_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? flow_treatment_pkg::RESP_OKAY : flow_treatment_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // only the two control bits are kept; the rest reads zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= flow_treatment_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_next & 32'h0000_0003;
    end
  end

  // register bus, read side
  // one read in flight; the next address waits until the data is taken
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  wire [11:0] ra = {s_axi_araddr[11:2], 2'h0};
  // status holds the enable bit and the hit and multicast-fail flags of the last taken header
  wire [31:0] status_word = {29'h0, last_mcast_fail_reg, last_hit_reg, decode_en};
  wire        rd_ok       = reg_mapped(ra);
  logic [31:0] rd_mux;
  // unmapped offsets read zero and answer with an error
  always_comb begin
    rd_mux = 32'h0;
    if (ra == flow_treatment_pkg::CTRL_OFFSET) begin
      rd_mux = ctrl_reg;
    end else if (ra == flow_treatment_pkg::STATUS_OFFSET) begin
      rd_mux = status_word;
    end else if (ra == flow_treatment_pkg::DROP_CNT_OFFSET) begin
      rd_mux = drop_cnt_reg;
    end else if (ra == flow_treatment_pkg::DIVERT_CNT_OFFSET) begin
      rd_mux = divert_cnt_reg;
    end else if (ra == flow_treatment_pkg::LAST_TW_OFFSET) begin
      rd_mux = {16'h0, last_tw_reg};
    end else if (ra == flow_treatment_pkg::FWD_CNT_OFFSET) begin
      rd_mux = fwd_cnt_reg;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= flow_treatment_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_ok ? flow_treatment_pkg::RESP_OKAY : flow_treatment_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

// *** verif/flow_treatment_props.sv ***
// checker: result relations of the treatment decoder at its top ports
`timescale 1ns/1ps
module flow_treatment_props (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        pkt_valid,
  input wire logic        pkt_multicast,
  input wire logic        flow_hit,
  input wire logic [7:0]  pkt_ds,
  input wire logic [15:0] flow_assoc_data,
  input wire logic [15:0] route_match_index,
  input wire logic [15:0] transport_match_index,
  input wire logic        mark_wr,
  input wire logic [15:0] mark_wr_word,
  input wire logic        out_valid,
  input wire logic        out_drop,
  input wire logic [15:0] out_portmap,
  input wire logic [2:0]  out_queue,
  input wire logic [7:0]  out_ds,
  input wire logic [7:0]  out_reason,
  input wire logic [15:0] out_route_index,
  input wire logic [15:0] out_transport_index
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // header with a flow hit, then its result one cycle later
  sequence s_hit(m);
    pkt_valid && flow_hit && m ##1 out_valid;
  endsequence
  chk_drop_clears: assert property (out_valid && out_drop |-> out_portmap == 16'h0 && out_reason == 8'h0)
    else $error("dropped result still routed");
  chk_drop_flag: assert property (s_hit(flow_assoc_data[4]) |-> out_drop)
    else $error("drop flag ignored");
  chk_host_slot: assert property (s_hit(!pkt_multicast && flow_assoc_data[4:3] == 2'b01) |->
      !out_drop && out_portmap == 16'h0001 && out_reason == flow_treatment_pkg::REASON_FLOW_DIVERT)
    else $error("host divert not sent to port zero");
  chk_ds_keep: assert property (s_hit(!flow_assoc_data[6]) |-> out_ds == $past(pkt_ds))
    else $error("ds changed without request");
  chk_ds_full: assert property (s_hit(flow_assoc_data[7:6] == 2'b11) |-> out_ds == $past(flow_assoc_data[15:8]))
    else $error("full ds rewrite wrong");
  chk_ds_part: assert property (s_hit(flow_assoc_data[7:6] == 2'b01) |->
      out_ds == {$past(flow_assoc_data[15:10]), $past(pkt_ds[1:0])})
    else $error("partial ds rewrite wrong");
  chk_queue_num: assert property (s_hit(1'b1) |-> out_queue == $past(flow_assoc_data[2:0]))
    else $error("queue number wrong");
  chk_mark_wb: assert property (s_hit(1'b1) |-> mark_wr && mark_wr_word == ($past(flow_assoc_data) | 16'h0020))
    else $error("access mark not written back");
  chk_index_pair: assert property (out_valid |-> out_route_index == $past(route_match_index) &&
      out_transport_index == $past(transport_match_index))
    else $error("match indices not carried");
  chk_mark_gate: assert property (mark_wr |-> out_valid && $past(flow_hit))
    else $error("access mark written without a flow hit");
endmodule

// *** verif/lookup_partner.sv ***
// partner: default table of the lookup side, one word per transport port
`timescale 1ns/1ps
module lookup_partner (
  input  wire logic [15:0] src_default_index,
  input  wire logic [15:0] dst_default_index,
  output logic      [15:0] src_default_word,
  output logic      [15:0] dst_default_word
);
  // hashed contents: equal queue numbers still occur, so ties get exercised
  function automatic logic [15:0] entry(input logic [15:0] i);
    return (i * 16'h9e37) ^ 16'h5a5a;
  endfunction
  assign src_default_word = entry(src_default_index);
  assign dst_default_word = entry(dst_default_index);
endmodule

// *** verif/flow_treatment_decode_tb_top.sv ***
// testbench top: random headers, register access, result model
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp=%h got=%h", n, e, g); end end
module flow_treatment_decode_tb_top;
  logic mclk = 0, reset = 1, pkt_valid = 0, pkt_multicast = 0, flow_hit = 0;
  logic [31:0] src_addr = 0, dst_addr = 0, s_axi_wdata = 0, s_axi_rdata, rd, ternary_route_cam_key;
  logic [15:0] src_tport = 0, dst_tport = 0, flow_assoc_data = 0, route_portmap = 0;
  logic [15:0] route_match_index = 0, transport_match_index = 0, src_default_word, dst_default_word;
  logic [15:0] src_default_index, dst_default_index, mark_wr_word, out_portmap, out_route_index, out_transport_index;
  logic [3:0] bus_slot_port = 0, mcast_expected_slot = 0, s_axi_wstrb = 4'hf;
  logic [7:0] pkt_ds = 0, out_ds, out_reason;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] out_queue;
  logic [99:0] flow_key;
  logic [63:0] binary_flow_cam_key;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mark_wr, out_valid, out_drop;
  int bad_count = 0, num_checks = 0, drops = 0, diverts = 0;
  bit en = 1, mchk = 0;
  logic [67:0] expq[$];

  always #4 mclk = ~mclk;
  flow_treatment_decode i_flow_treatment_decode (.*);
  lookup_partner i_lookup_partner (.*);

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one bus transfer; ready and answers are stable from the falling edge to the next rising one
  task automatic axi(input bit wr, input logic [11:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge mclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
    end
    for (int i = 0; i < 60; i++) begin
      @(negedge mclk);
      ah = wr ? s_axi_awready : s_axi_arready;
      wh = s_axi_wready;
      bh = wr ? s_axi_bvalid : s_axi_rvalid;
      if (bh) rsp = wr ? s_axi_bresp : s_axi_rresp;
      if (bh) rd = s_axi_rdata;
      @(posedge mclk);
      if (wr && ah) s_axi_awvalid <= 0;
      if (wr && wh) s_axi_wvalid <= 0;
      if (!wr && ah) s_axi_arvalid <= 0;
      if (wr && bh) s_axi_bready <= 0;
      if (!wr && bh) s_axi_rready <= 0;
      if (bh) return;
    end
    bad_count++;
    $display("unexpected bus_answer exp=%h got=%h", 1'b1, 1'b0);
    complete_run();
  endtask

  task automatic pkts(input int n);
    repeat (n) begin
      @(posedge mclk);
      pkt_valid <= ($urandom % 5) != 0;
      src_addr <= $urandom;
      dst_addr <= $urandom;
      src_tport <= 16'($urandom);
      dst_tport <= 16'($urandom);
      bus_slot_port <= 4'($urandom % 3);
      mcast_expected_slot <= 4'($urandom % 3);
      pkt_ds <= 8'($urandom);
      pkt_multicast <= 1'($urandom);
      flow_hit <= 1'($urandom);
      flow_assoc_data <= 16'($urandom);
      route_portmap <= 16'($urandom);
      route_match_index <= 16'($urandom);
      transport_match_index <= 16'($urandom);
    end
    @(posedge mclk);
    pkt_valid <= 0;
  endtask

  // result first, then the expectation of the header now on the inputs
  always @(negedge mclk) begin
    logic [15:0] c;
    logic dr;
    logic [67:0] e;
    if (out_valid !== 1'b0) begin
      e = expq.size() ? expq.pop_front() : 'x;
      `CHK("fate", e[67:43], {out_drop, out_portmap, out_reason})
      `CHK("treatment", e[42:32], {out_queue, out_ds})
      `CHK("indices", e[31:0], {out_route_index, out_transport_index})
    end
    if (pkt_valid === 1'b1) begin
      `CHK("flow_key", {src_addr, dst_addr, src_tport, dst_tport, bus_slot_port}, flow_key)
      `CHK("cam_keys", {src_addr ^ dst_addr, src_tport, dst_tport, dst_addr}, {binary_flow_cam_key, ternary_route_cam_key})
      `CHK("default_idx", {src_tport, dst_tport}, {src_default_index, dst_default_index})
      if (en) begin
        c = flow_hit ? flow_assoc_data : (src_default_word[2:0] <= dst_default_word[2:0]) ? src_default_word : dst_default_word;
        dr = c[4] | (mchk & pkt_multicast & (bus_slot_port != mcast_expected_slot));
        drops += dr;
        diverts += !dr & c[3];
        expq.push_back({dr, dr ? 16'h0 : c[3] ? 16'h0001 : route_portmap, (!dr & c[3]) ? 8'h01 : 8'h00, c[2:0],
                        !c[6] ? pkt_ds : c[7] ? c[15:8] : {c[15:10], pkt_ds[1:0]}, route_match_index, transport_match_index});
      end
    end
  end

  initial begin
    void'($urandom(67595));
    repeat (16) @(posedge mclk);
    reset <= 0;
    axi(0, flow_treatment_pkg::CTRL_OFFSET, 0);
    `CHK("ctrl_reset", flow_treatment_pkg::CTRL_RESET, rd)
    axi(0, 12'h100, 0);
    `CHK("unmapped_read", {flow_treatment_pkg::RESP_SLVERR, 32'h0}, {rsp, rd})
    pkts(150);
    mchk = 1;
    axi(1, flow_treatment_pkg::CTRL_OFFSET, 32'h3);
    pkts(150);
    // decode off: any result now finds an empty model queue
    en = 0;
    axi(1, flow_treatment_pkg::CTRL_OFFSET, 32'h1);
    pkts(20);
    axi(1, flow_treatment_pkg::DROP_CNT_OFFSET, 32'hffffffff);
    `CHK("ro_write_resp", flow_treatment_pkg::RESP_OKAY, rsp)
    axi(0, flow_treatment_pkg::DROP_CNT_OFFSET, 0);
    `CHK("drop_count", 32'(drops), rd)
    axi(0, flow_treatment_pkg::DIVERT_CNT_OFFSET, 0);
    `CHK("divert_count", 32'(diverts), rd)
    axi(1, 12'h100, 32'h1);
    `CHK("unmapped_write", flow_treatment_pkg::RESP_SLVERR, rsp)
    // no strobe set: the control word must keep its value
    s_axi_wstrb <= 4'h0;
    axi(1, flow_treatment_pkg::CTRL_OFFSET, 32'h2);
    axi(0, flow_treatment_pkg::CTRL_OFFSET, 0);
    `CHK("strobe_mask", 32'h1, rd)
    repeat (3) @(posedge mclk);
    `CHK("pending", 32'h0, 32'(expq.size()))
    complete_run();
  end
endmodule

bind flow_treatment_decode flow_treatment_props i_flow_treatment_props (.*);
